// ---- design/clk_divider.sv ----
// Power-of-two divider of the reference clock, gated by an enable.
// Assumes the reference enters as a synchronised level; output toggles in CLK.
`timescale 1ns/1ps
module clk_divider (
  input wire logic clk,
  input wire logic srst,
  input wire logic ref_in,
  input wire logic enable,
  input wire logic [2:0] ratio,
  output logic clk_out
);
  import synth_ctl_pkg::*;
  logic ref_d_ff;
  logic [7:0] cnt_ff;
  logic out_ff;
  logic rise;
  assign rise = ref_in & ~ref_d_ff;
  // Edge detect on the synchronised reference
  always_ff @(posedge clk) begin
    if (srst) begin
      ref_d_ff <= 1'b0;
    end else begin
      ref_d_ff <= ref_in;
    end
  end
  // Counts reference edges; held at zero when disabled to save toggling
  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      cnt_ff <= 8'h00;
    end else if (rise) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // Ratio 0 passes the reference, else bit ratio-1 of the count is 1/2^ratio
  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      out_ff <= 1'b0;
    end else if (ratio == 3'h0) begin
      out_ff <= ref_in;
    end else begin
      out_ff <= cnt_ff[ratio - 3'h1];
    end
  end
  assign clk_out = out_ff;
endmodule

// ---- design/sync_in.sv ----
// Three-flop input synchroniser; output changes once stages two and three agree.
// Assumes the input is asynchronous to CLK.
`timescale 1ns/1ps
module sync_in (
  input wire logic clk,
  input wire logic srst,
  input wire logic d,
  output logic q
);
  import synth_ctl_pkg::*;
  logic [SYNC_STAGES-1:0] stage_ff;
  logic q_ff;
  // Shift chain; first stage only feeds the second
  always_ff @(posedge clk) begin
    if (srst) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= {stage_ff[SYNC_STAGES-2:0], d};
    end
  end
  // Accept a change only once the last two stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      q_ff <= 1'b0;
    end else if (stage_ff[1] == stage_ff[2]) begin
      q_ff <= stage_ff[2];
    end
  end
  assign q = q_ff;
endmodule

// ---- design/synth_ctl.sv ----
// Synthesizer control and lock status block with APB register access.
// Assumes reference and lock inputs arrive from outside the CLK domain.
// Behaviour
// - When clock output enable is set the reference or its divided version drives the clock output pin.
// - The clock output is divided by two to the power of the value in the clock output divider field.
// - The clock output works in every mode except sleep, where it is held off.
// - After reset the clock output is enabled with no software write.
// - Each tank trim step up from 00 raises the tuning voltage about 60 mV.
// - Lock status is a readable flag that stays set until software writes a one to it.
// - With lock pin enable set the lock pin mirrors the lock status.
// - Six divider bytes for two frequency sets sit at configuration indices 6 to 11.
`timescale 1ns/1ps
module synth_ctl (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic XTAL_REF,
  input wire logic SYNTH_LOCKED,
  output logic CLOCK_OUT,
  output logic LOCK_PIN,
  output logic [1:0] SYNTH_BAND_SELECT,
  output logic [1:0] OSCILLATOR_TANK_TRIM,
  output logic [47:0] DIVIDER_BYTES,
  output logic IRQ
);
  import synth_ctl_pkg::*;

  logic clock_out_enable_ff;
  logic [2:0] clock_out_divider_ff;
  logic [1:0] synth_band_select_ff;
  logic [1:0] oscillator_tank_trim_ff;
  logic synth_lock_flag_ff;
  logic lock_pin_enable_ff;
  logic sleep_mode_ff;
  logic [7:0] div_ff [DIV_COUNT];
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic lock_pin_ff;
  logic irq_ff;
  logic clock_out_ff;
  logic lock_prev_ff;
  logic ref_sync;
  logic lock_sync;
  logic div_clk;
  logic pready_ff;
  logic wr_en;
  logic wr_clkout;
  logic wr_band;
  logic wr_trim;
  logic wr_lock;
  logic wr_stat;
  logic wr_mask;
  logic wr_mode;
  logic addr_ok;
  logic lock_rise;
  logic lock_fall;
  logic [31:0] nxt_prdata;

  // Bus strobes; ready is up in the first access cycle, so no wait states
  assign wr_en = PSEL & PENABLE & PWRITE & pready_ff;
  assign lock_rise = lock_sync & ~lock_prev_ff;
  assign lock_fall = ~lock_sync & lock_prev_ff;

  // Per-register write strobes, decoded once for all update processes but the divider bytes, which decode their own
  assign wr_clkout = wr_en & (PADDR == ADDR_CLKOUT);
  assign wr_band = wr_en & (PADDR == ADDR_BAND);
  assign wr_trim = wr_en & (PADDR == ADDR_TRIM);
  assign wr_lock = wr_en & (PADDR == ADDR_LOCK);
  assign wr_stat = wr_en & (PADDR == ADDR_IRQ_STAT);
  assign wr_mask = wr_en & (PADDR == ADDR_IRQ_MASK);
  assign wr_mode = wr_en & (PADDR == ADDR_MODE);

  // Address decode; divider words cover six consecutive words
  always_comb begin
    addr_ok = 1'b0;
    if (PADDR[1:0] == 2'h0) begin
      case (PADDR)
        ADDR_CLKOUT, ADDR_BAND, ADDR_TRIM, ADDR_LOCK, ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_MODE: begin
          addr_ok = 1'b1;
        end
        default: begin
          addr_ok = (PADDR >= ADDR_DIV_BASE) && (PADDR < ADDR_IRQ_STAT);
        end
      endcase
    end
  end

  // Inputs from the crystal and the analog lock detector
  sync_in u_ref_sync (
    .clk(CLK),
    .srst(SRST),
    .d(XTAL_REF),
    .q(ref_sync)
  );
  sync_in u_lock_sync (
    .clk(CLK),
    .srst(SRST),
    .d(SYNTH_LOCKED),
    .q(lock_sync)
  );

  // Divider counts only when enabled and not asleep; otherwise its count and output are held at zero, but its reference edge flop keeps running
  clk_divider u_div (
    .clk(CLK),
    .srst(SRST),
    .ref_in(ref_sync),
    .enable(clock_out_enable_ff & ~sleep_mode_ff),
    .ratio(clock_out_divider_ff),
    .clk_out(div_clk)
  );

  // Clock output control; enabled out of reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      clock_out_enable_ff <= CLKOUT_EN_RST;
      clock_out_divider_ff <= CLKOUT_DIV_RST;
    end else if (wr_clkout) begin
      clock_out_enable_ff <= PWDATA[CLKOUT_EN_BIT];
      clock_out_divider_ff <= PWDATA[CLKOUT_DIV_LSB +: CLKOUT_DIV_W];
    end
  end

  // Clock output pin register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      clock_out_ff <= 1'b0;
    end else begin
      clock_out_ff <= div_clk & clock_out_enable_ff & ~sleep_mode_ff;
    end
  end

  // Band select, driven to the analog side; software owns the encoding
  always_ff @(posedge CLK) begin
    if (SRST) begin
      synth_band_select_ff <= BAND_RST;
    end else if (wr_band) begin
      synth_band_select_ff <= PWDATA[1:0];
    end
  end

  // Tank trim; stored as written, software steps it while watching the tuning voltage
  always_ff @(posedge CLK) begin
    if (SRST) begin
      oscillator_tank_trim_ff <= TRIM_RST;
    end else if (wr_trim) begin
      oscillator_tank_trim_ff <= PWDATA[1:0];
    end
  end

  // Sleep mode control
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sleep_mode_ff <= MODE_SLEEP_RST;
    end else if (wr_mode) begin
      sleep_mode_ff <= PWDATA[0];
    end
  end

  // Divider bytes; range limits are software's job, stored as written
  genvar gi;
  generate
    for (gi = 0; gi < DIV_COUNT; gi++) begin : g_div
      always_ff @(posedge CLK) begin
        if (SRST) begin
          div_ff[gi] <= DIV_RST;
        end else if (wr_en && PADDR == ADDR_DIV_BASE + 8'(4 * gi)) begin
          div_ff[gi] <= PWDATA[7:0];
        end
      end
      assign DIVIDER_BYTES[8*gi +: 8] = div_ff[gi];
    end
  endgenerate

  // Lock edge detector on the synchronised level
  always_ff @(posedge CLK) begin
    if (SRST) begin
      lock_prev_ff <= 1'b0;
    end else begin
      lock_prev_ff <= lock_sync;
    end
  end

  // Sticky lock flag; a new lock in the clearing cycle wins
  always_ff @(posedge CLK) begin
    if (SRST) begin
      synth_lock_flag_ff <= 1'b0;
    end else if (lock_rise) begin
      synth_lock_flag_ff <= 1'b1;
    end else if (wr_lock && PWDATA[LOCK_FLAG_BIT]) begin
      synth_lock_flag_ff <= 1'b0;
    end
  end

  // Lock pin enable
  always_ff @(posedge CLK) begin
    if (SRST) begin
      lock_pin_enable_ff <= 1'b0;
    end else if (wr_lock) begin
      lock_pin_enable_ff <= PWDATA[LOCK_PIN_EN_BIT];
    end
  end

  // Lock pin mirrors the sticky status while enabled
  always_ff @(posedge CLK) begin
    if (SRST) begin
      lock_pin_ff <= 1'b0;
    end else begin
      lock_pin_ff <= lock_pin_enable_ff & synth_lock_flag_ff;
    end
  end

  // Interrupt status: bit0 lock gained, bit1 lock lost; set wins over clear
  always_ff @(posedge CLK) begin
    if (SRST) begin
      irq_stat_ff <= IRQ_STAT_RST;
    end else if (wr_stat) begin
      irq_stat_ff <= (irq_stat_ff & ~PWDATA[1:0]) | {lock_fall, lock_rise};
    end else begin
      irq_stat_ff <= irq_stat_ff | {lock_fall, lock_rise};
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK) begin
    if (SRST) begin
      irq_mask_ff <= IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_ff <= PWDATA[1:0];
    end
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge CLK) begin
    if (SRST) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Read mux
  always_comb begin
    nxt_prdata = 32'h00000000;
    case (PADDR)
      ADDR_CLKOUT: nxt_prdata = {28'h0000000, clock_out_divider_ff, clock_out_enable_ff};
      ADDR_BAND: nxt_prdata = {30'h00000000, synth_band_select_ff};
      ADDR_TRIM: nxt_prdata = {30'h00000000, oscillator_tank_trim_ff};
      ADDR_LOCK: nxt_prdata = {30'h00000000, lock_pin_enable_ff, synth_lock_flag_ff};
      ADDR_IRQ_STAT: nxt_prdata = {30'h00000000, irq_stat_ff};
      ADDR_IRQ_MASK: nxt_prdata = {30'h00000000, irq_mask_ff};
      ADDR_MODE: nxt_prdata = {31'h00000000, sleep_mode_ff};
      default: begin
        for (int i = 0; i < DIV_COUNT; i++) begin
          if (PADDR == ADDR_DIV_BASE + 8'(4 * i)) begin
            nxt_prdata = {24'h000000, div_ff[i]};
          end
        end
      end
    endcase
  end

  // Read data and error captured in setup phase, presented in access phase
  always_ff @(posedge CLK) begin
    if (SRST) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      prdata_ff <= PWRITE ? 32'h00000000 : nxt_prdata;
      pslverr_ff <= ~addr_ok;
    end else if (!PSEL) begin
      pslverr_ff <= 1'b0;
    end
  end

  // Ready only in the access phase, so each transfer ends after one access cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= PSEL & ~PENABLE;
    end
  end

  assign PRDATA = prdata_ff;
  assign PSLVERR = pslverr_ff;
  assign PREADY = pready_ff;
  assign CLOCK_OUT = clock_out_ff;
  assign LOCK_PIN = lock_pin_ff;
  assign SYNTH_BAND_SELECT = synth_band_select_ff;
  assign OSCILLATOR_TANK_TRIM = oscillator_tank_trim_ff;
  assign IRQ = irq_ff;
endmodule

// ---- design/synth_ctl_pkg.sv ----
// Package for the synthesizer control block: register map, fields, reset values.
// Assumes a 32-bit APB slave with one register per aligned word.
package synth_ctl_pkg;
  localparam logic [7:0] ADDR_CLKOUT = 8'h00;
  localparam logic [7:0] ADDR_BAND = 8'h04;
  localparam logic [7:0] ADDR_TRIM = 8'h08;
  localparam logic [7:0] ADDR_LOCK = 8'h0C;
  localparam logic [7:0] ADDR_DIV_BASE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
  localparam logic [7:0] ADDR_MODE = 8'h30;
  localparam int DIV_COUNT = 6;
  localparam int DIV_FIRST_INDEX = 6;
  localparam int CLKOUT_EN_BIT = 0;
  localparam int CLKOUT_DIV_LSB = 1;
  localparam int CLKOUT_DIV_W = 3;
  localparam int LOCK_FLAG_BIT = 0;
  localparam int LOCK_PIN_EN_BIT = 1;
  localparam logic CLKOUT_EN_RST = 1'b1;
  localparam logic [2:0] CLKOUT_DIV_RST = 3'h0;
  localparam logic [1:0] BAND_RST = 2'h0;
  localparam logic [1:0] TRIM_RST = 2'h0;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [1:0] IRQ_STAT_RST = 2'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic MODE_SLEEP_RST = 1'b0;
  localparam int SYNC_STAGES = 3;
endpackage

// ---- tb/synth_config_and_lock_status_bench.sv ----
// Self-checking bench for synth_ctl over APB.
// Assumes the reference period is 16 clock cycles.
`timescale 1ns/1ps
module synth_config_and_lock_status_bench;
  import synth_ctl_pkg::*;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lock_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, xtal_ref, synth_locked, clock_out, lock_pin, irq, err;
  logic [1:0] band, trim;
  logic [47:0] div_bytes;
  int miscompares = 0, tests_run = 0;
  always #10 clk = ~clk;
  xtal_lock_model PARTNER (.clk(clk), .lock_req(lock_req), .ref_clk(xtal_ref), .locked(synth_locked));
  synth_ctl DUT (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .XTAL_REF(xtal_ref),
    .SYNTH_LOCKED(synth_locked), .CLOCK_OUT(clock_out), .LOCK_PIN(lock_pin), .SYNTH_BAND_SELECT(band),
    .OSCILLATOR_TANK_TRIM(trim), .DIVIDER_BYTES(div_bytes), .IRQ(irq));
  task finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  // One APB transfer; request held until pready seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      finish_test;
    end
  endtask
  // Rising edges of the clock output over a window
  task rises(input int cycles, output int n);
    logic prev;
    n = 0;
    prev = clock_out;
    repeat (cycles) begin
      @(posedge clk);
      if (clock_out === 1'b1 && prev === 1'b0) n++;
      prev = clock_out;
    end
  endtask
  task t_clkout;
    int n;
    apb(0, ADDR_CLKOUT, 0);
    chk("clkout reset", 48'({CLKOUT_DIV_RST, CLKOUT_EN_RST}), 48'(rd));
    rises(64, n);
    chk("clkout at reset", 1, 48'(n >= 3));
    // Window of eight output periods for every ratio, so each expects 7 to 9 rises
    for (int r = 0; r < 8; r++) begin
      apb(1, ADDR_CLKOUT, 32'((r << 1) | 1));
      repeat (300) @(posedge clk);
      rises(128 << r, n);
      chk("clkout rate", 1, 48'(n >= 7 && n <= 9));
    end
    apb(1, ADDR_CLKOUT, 32'h0);
    repeat (8) @(posedge clk);
    rises(128, n);
    chk("clkout disabled", 0, 48'(n));
    apb(1, ADDR_CLKOUT, 32'h1);
    apb(1, ADDR_MODE, 32'h1);
    repeat (8) @(posedge clk);
    rises(128, n);
    chk("clkout sleep", 0, 48'(n));
    apb(1, ADDR_MODE, 32'h0);
    repeat (8) @(posedge clk);
    rises(128, n);
    chk("clkout awake", 1, 48'(n >= 7));
  endtask
  task t_fields;
    logic [7:0] v [6];
    v = '{8'h77, 8'h3C, 8'h20, 8'h77, 8'h41, 8'h41};
    for (int i = 0; i < 4; i++) begin
      apb(1, ADDR_BAND, 32'(i));
      apb(1, ADDR_TRIM, 32'(i));
      repeat (2) @(posedge clk);
      chk("band", 48'(i), 48'(band));
      chk("trim", 48'(i), 48'(trim));
    end
    for (int i = 0; i < 6; i++) apb(1, ADDR_DIV_BASE + 8'(4 * i), 32'(v[i]));
    repeat (2) @(posedge clk);
    chk("dividers", {v[5], v[4], v[3], v[2], v[1], v[0]}, div_bytes);
    apb(0, 8'hF0, 0);
    chk("unmapped err", 1, 48'(err));
    chk("unmapped data", 0, 48'(rd));
  endtask
  task t_lock;
    apb(1, ADDR_IRQ_MASK, 32'h1);
    apb(1, ADDR_LOCK, 32'h2);
    lock_req <= 1'b1;
    repeat (12) @(posedge clk);
    apb(0, ADDR_LOCK, 0);
    chk("lock reg", 48'h3, 48'(rd));
    chk("lock pin", 1, 48'(lock_pin));
    chk("irq raised", 1, 48'(irq));
    lock_req <= 1'b0;
    repeat (12) @(posedge clk);
    apb(1, ADDR_LOCK, 32'h2);
    repeat (2) @(posedge clk);
    chk("flag kept", 1, 48'(lock_pin));
    apb(1, ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, 48'(irq));
    apb(1, ADDR_IRQ_STAT, 32'h3);
    apb(1, ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, 48'(irq));
    apb(1, ADDR_LOCK, 32'h3);
    repeat (2) @(posedge clk);
    chk("flag cleared", 0, 48'(lock_pin));
    apb(1, ADDR_LOCK, 32'h0);
    lock_req <= 1'b1;
    repeat (12) @(posedge clk);
    apb(0, ADDR_LOCK, 0);
    chk("pin off", 0, 48'(lock_pin));
    chk("flag only", 48'h1, 48'(rd));
    chk("irq again", 1, 48'(irq));
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_clkout();
    t_fields();
    t_lock();
    finish_test();
  end
endmodule

// ---- tb/synth_ctl_assertions.sv ----
// Port checker for synth_ctl.
// Assumes binding to every synth_ctl instance.
`timescale 1ns/1ps
module synth_ctl_assertions
  import synth_ctl_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PSLVERR,
  input wire logic SYNTH_LOCKED,
  input wire logic CLOCK_OUT,
  input wire logic LOCK_PIN,
  input wire logic [1:0] SYNTH_BAND_SELECT,
  input wire logic [1:0] OSCILLATOR_TANK_TRIM,
  input wire logic [47:0] DIVIDER_BYTES,
  input wire logic IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic wr;
  logic wr_lock;
  logic [31:0] wd_ff;
  // Write strobe, and last cycle's data for field checks
  assign wr = PSEL && PENABLE && PWRITE;
  assign wr_lock = wr && PADDR == ADDR_LOCK;
  always_ff @(posedge CLK) begin
    wd_ff <= PWDATA;
  end
  property p_band; wr && PADDR == ADDR_BAND |=> SYNTH_BAND_SELECT == wd_ff[1:0]; endproperty
  a_band: assert property (p_band) else $error("band select missed write");
  property p_trim; wr && PADDR == ADDR_TRIM |=> OSCILLATOR_TANK_TRIM == wd_ff[1:0]; endproperty
  a_trim: assert property (p_trim) else $error("tank trim missed write");
  property p_div; wr && PADDR == ADDR_DIV_BASE |=> DIVIDER_BYTES[7:0] == wd_ff[7:0]; endproperty
  a_div: assert property (p_div) else $error("first divider byte missed write");
  property p_keep; LOCK_PIN && !$past(wr_lock) |=> LOCK_PIN; endproperty
  a_keep: assert property (p_keep) else $error("lock indication dropped by itself");
  property p_clear; (!SYNTH_LOCKED)[*8] ##0 (wr_lock && PWDATA[0]) |-> ##2 !LOCK_PIN; endproperty
  a_clear: assert property (p_clear) else $error("lock flag not cleared by one");
  property p_zero; wr_lock && !PWDATA[0] && PWDATA[1] && LOCK_PIN |-> ##2 LOCK_PIN; endproperty
  a_zero: assert property (p_zero) else $error("lock flag lost on zero write");
  property p_pin; wr_lock && !PWDATA[1] |-> ##2 !LOCK_PIN; endproperty
  a_pin: assert property (p_pin) else $error("lock pin driven while disabled");
  property p_off; wr && PADDR == ADDR_CLKOUT && !PWDATA[0] |-> ##3 !CLOCK_OUT; endproperty
  a_off: assert property (p_off) else $error("clock out runs while disabled");
  property p_sleep; wr && PADDR == ADDR_MODE && PWDATA[0] |-> ##3 !CLOCK_OUT; endproperty
  a_sleep: assert property (p_sleep) else $error("clock out runs in sleep");
  property p_irq; wr && PADDR == ADDR_IRQ_MASK && PWDATA[1:0] == 2'h0 |-> ##2 !IRQ; endproperty
  a_irq: assert property (p_irq) else $error("irq high with all masked");
  // Main scenarios reached
  cover property (wr_lock && PWDATA[0]);
  cover property ($rose(LOCK_PIN));
  cover property ($rose(IRQ));
endmodule
bind synth_ctl synth_ctl_assertions CHK (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR), .SYNTH_LOCKED(SYNTH_LOCKED),
  .CLOCK_OUT(CLOCK_OUT), .LOCK_PIN(LOCK_PIN), .SYNTH_BAND_SELECT(SYNTH_BAND_SELECT),
  .OSCILLATOR_TANK_TRIM(OSCILLATOR_TANK_TRIM), .DIVIDER_BYTES(DIVIDER_BYTES), .IRQ(IRQ));

// ---- tb/xtal_lock_model.sv ----
// Model of the crystal reference and the analog lock detector.
// Assumes the bench gives the system clock and a lock request.
`timescale 1ns/1ps
module xtal_lock_model #(parameter int HALF = 8) (
  input wire logic clk,
  input wire logic lock_req,
  output logic ref_clk,
  output logic locked
);
  int cnt = 0;
  logic tog = 1'b0;
  logic lk = 1'b0;
  // Reference far below the synchroniser limit, else edges are lost
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) tog <= ~tog;
    lk <= lock_req;
  end
  assign ref_clk = tog;
  assign locked = lk;
endmodule
